// [dpg_pkg.sv]
// package: dual pulse generator register map, fields, modes, clock selects
package dpg_pkg;
    // ************************************************************
    // register offsets (word index on the plain port)
    // ************************************************************
    localparam logic [2:0] REG_LOWER_CTRL  = 3'h0;
    localparam logic [2:0] REG_UPPER_CTRL  = 3'h1;
    localparam logic [2:0] REG_PAIR_SEL    = 3'h2;
    localparam logic [2:0] REG_RELOAD_LOW  = 3'h3;
    localparam logic [2:0] REG_RELOAD_UP   = 3'h4;
    localparam logic [2:0] REG_STATUS      = 3'h5;
    // ************************************************************
    // channel control fields
    // ************************************************************
    localparam int BIT_RUN_EN   = 7;
    localparam int BIT_PIN_EN   = 6;
    localparam int BIT_IRQ_EN   = 5;
    localparam int BIT_UF_FLAG  = 4;
    localparam int BIT_MODE_LSB = 2;
    // ************************************************************
    // pair select fields
    // ************************************************************
    localparam int BIT_SWAP        = 0;
    localparam int BIT_LOWER_CS    = 2;
    localparam int BIT_UPPER_CS    = 5;
    // ************************************************************
    // reset values and codes
    // ************************************************************
    localparam logic [7:0] CTRL_RESET     = 8'h00;
    localparam logic [7:0] PAIR_RESET     = 8'h00;
    localparam logic [7:0] RELOAD_RESET   = 8'h00;
    localparam logic [2:0] CS_TIMEBASE    = 3'h7;
    localparam logic [3:0] PRESCALE_WIDTH = 4'h4;
    typedef enum logic [1:0] {
        MODE_INDEP   = 2'h0,
        MODE_CASCADE = 2'h1,
        MODE_BAD     = 2'h2,
        MODE_WIDE    = 2'h3
    } dpg_mode_type;
endpackage

// [dpg_channel.sv]
// one 8-bit down counter channel with alternating reload
`timescale 1ns/100ps
module dpg_channel
    import dpg_pkg::*;
(
    // clocking
    input  wire logic       clk_sys,
    input  wire logic       rst,
    input  wire logic       clkEn,
    // control
    input  wire logic       runEn,
    input  wire logic       tick,
    input  wire logic       forceReload,
    input  wire logic       forcePhaseHigh,
    input  wire logic [7:0] lowReload,
    input  wire logic [7:0] highReload,
    // status
    output logic            atZero,
    output logic            underflow,
    output logic            pulseLevel
);
    logic [7:0] count_r;
    logic       phase_r;
    logic       running_r;
    logic       zeroHit;
    logic       reloadNow;
    logic       nextPhase;
    logic [7:0] reloadVal;

    assign atZero    = (count_r == 8'h00);
    // reload plus one ticks
    // a channel stopped this cycle reports no underflow
    assign zeroHit   = running_r && runEn && tick && atZero;
    assign underflow = zeroHit;
    assign reloadNow = zeroHit || (running_r && forceReload);
    assign nextPhase = forceReload ? forcePhaseHigh : ~phase_r;
    assign reloadVal = nextPhase ? highReload : lowReload;
    assign pulseLevel = phase_r;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            count_r   <= 8'h00;
            phase_r   <= 1'b0;
            running_r <= 1'b0;
        end else if (clkEn) begin
            if (!runEn) begin
                running_r <= 1'b0;
                phase_r   <= 1'b0;
            end else if (!running_r) begin
                // start on low phase
                running_r <= 1'b1;
                phase_r   <= 1'b0;
                count_r   <= lowReload;
            end else if (reloadNow) begin
                phase_r <= nextPhase;
                count_r <= reloadVal;
            end else if (tick) begin
                count_r <= count_r - 8'h01;
            end
        end
    end
endmodule

// [dpg_top.sv]
// top: dual 8-bit / single 16-bit pulse generator with register port
`timescale 1ns/100ps
module dpg_top
    import dpg_pkg::*;
(
    // clocking
    input  wire logic       clk_sys,
    input  wire logic       rst,
    input  wire logic       clkEn,
    // timebase tap
    input  wire logic       timebaseTap,
    // register port
    input  wire logic [2:0] regAddr,
    input  wire logic [15:0] regWdata,
    input  wire logic       regWr,
    input  wire logic       regRd,
    output logic [15:0]     regRdata,
    // pins and requests
    output logic            pulsePinLower,
    output logic            pulsePinUpper,
    output logic            irqLower,
    output logic            irqUpper
);
    // ************************************************************
    // registers
    // ************************************************************
    logic [7:0]  lowerCtrl_r;
    logic [7:0]  upperCtrl_r;
    logic [7:0]  pairSel_r;
    logic [7:0]  lowReloadLower_r;
    logic [7:0]  highReloadLower_r;
    logic [7:0]  lowReloadUpper_r;
    logic [7:0]  highReloadUpper_r;
    logic        ufLower_r;
    logic        ufUpper_r;
    logic [15:0] regRdata_r;
    logic        pinLower_r;
    logic        pinUpper_r;
    logic        irqLower_r;
    logic        irqUpper_r;
    logic [3:0]  prescale_r;
    logic [3:0]  prescalePrev_r;
    logic        tbSync1_r;
    logic        tbSync2_r;
    logic        tbPrev_r;
    logic        widePhase_r;

    // ************************************************************
    // decode
    // ************************************************************
    logic        wrLowerCtrl;
    logic        wrUpperCtrl;
    logic        wrPair;
    logic        wrRelLower;
    logic        wrRelUpper;
    logic        wrStatus;
    dpg_mode_type mode;
    logic        modeIndep;
    logic        modeWide;
    logic        modeCascade;
    logic        runLower;
    logic        runUpper;

    assign wrLowerCtrl = regWr && (regAddr == REG_LOWER_CTRL);
    assign wrUpperCtrl = regWr && (regAddr == REG_UPPER_CTRL);
    assign wrPair      = regWr && (regAddr == REG_PAIR_SEL);
    assign wrRelLower  = regWr && (regAddr == REG_RELOAD_LOW);
    assign wrRelUpper  = regWr && (regAddr == REG_RELOAD_UP);
    assign wrStatus    = regWr && (regAddr == REG_STATUS);
    assign mode        = dpg_mode_type'(upperCtrl_r[BIT_MODE_LSB +: 2]);
    assign modeIndep   = (mode == MODE_INDEP);
    assign modeWide    = (mode == MODE_WIDE);
    assign modeCascade = (mode == MODE_CASCADE);
    // per channel start in independent mode only; cascade and wide need both
    assign runLower = lowerCtrl_r[BIT_RUN_EN] &&
                      (modeIndep || upperCtrl_r[BIT_RUN_EN]);
    assign runUpper = upperCtrl_r[BIT_RUN_EN] &&
                      (modeIndep || lowerCtrl_r[BIT_RUN_EN]);

    // ************************************************************
    // count clock ticks
    // ************************************************************
    logic [7:0] divTick;
    logic       tbTick;
    logic       lowerTick;
    logic       upperTickSel;
    logic [2:0] lowerCs;
    logic [2:0] upperCs;

    assign lowerCs = pairSel_r[BIT_LOWER_CS +: 3];
    assign upperCs = pairSel_r[BIT_UPPER_CS +: 3];
    assign tbTick  = tbSync2_r && !tbPrev_r;
    assign divTick[0] = 1'b1;
    assign divTick[1] = prescale_r[0] && !prescalePrev_r[0];
    assign divTick[2] = prescale_r[1] && !prescalePrev_r[1];
    assign divTick[3] = prescale_r[2] && !prescalePrev_r[2];
    assign divTick[4] = prescale_r[3] && !prescalePrev_r[3];
    assign divTick[5] = 1'b0;
    assign divTick[6] = 1'b0;
    assign divTick[7] = tbTick;
    // division or timebase tap; other codes never tick
    assign lowerTick    = divTick[lowerCs];
    assign upperTickSel = divTick[upperCs];

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            prescale_r     <= 4'h0;
            prescalePrev_r <= 4'h0;
            tbSync1_r      <= 1'b0;
            tbSync2_r      <= 1'b0;
            tbPrev_r       <= 1'b0;
        end else if (clkEn) begin
            prescale_r     <= prescale_r + 4'h1;
            prescalePrev_r <= prescale_r;
            tbSync1_r      <= timebaseTap;
            tbSync2_r      <= tbSync1_r;
            tbPrev_r       <= tbSync2_r;
        end
    end

    // ************************************************************
    // channels
    // ************************************************************
    logic ufRawLower;
    logic ufRawUpper;
    logic levelLower;
    logic levelUpper;
    logic upperTick;
    logic ufLowerEv;
    logic ufUpperEv;

    // cascade clocks upper from lower underflow
    // wide: upper ticks on lower underflow
    assign upperTick = modeIndep   ? upperTickSel :
                       modeCascade ? ufRawLower :
                       modeWide    ? ufRawLower : 1'b0;

    dpg_channel u_lower (
        .clk_sys        (clk_sys),
        .rst            (rst),
        .clkEn          (clkEn),
        .runEn          (runLower),
        .tick           (lowerTick),
        .forceReload    (1'b0),
        .forcePhaseHigh (1'b0),
        .lowReload      (lowReloadLower_r),
        .highReload     (highReloadLower_r),
        .atZero         (),
        .underflow      (ufRawLower),
        .pulseLevel     (levelLower)
    );

    dpg_channel u_upper (
        .clk_sys        (clk_sys),
        .rst            (rst),
        .clkEn          (clkEn),
        .runEn          (runUpper),
        .tick           (upperTick),
        .forceReload    (1'b0),
        .forcePhaseHigh (1'b0),
        .lowReload      (lowReloadUpper_r),
        .highReload     (highReloadUpper_r),
        .atZero         (),
        .underflow      (ufRawUpper),
        .pulseLevel     (levelUpper)
    );

    // ************************************************************
    // wide mode: 16-bit counter kept here
    // ************************************************************
    logic [15:0] wideCnt_r;
    logic        wideRun_r;
    logic        wideUf;
    logic [15:0] wideLow;
    logic [15:0] wideHigh;

    assign wideLow  = {lowReloadUpper_r, lowReloadLower_r};
    assign wideHigh = {highReloadUpper_r, highReloadLower_r};
    assign wideUf   = wideRun_r && runLower && runUpper && lowerTick &&
                      (wideCnt_r == 16'h0000);

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            wideCnt_r   <= 16'h0000;
            wideRun_r   <= 1'b0;
            widePhase_r <= 1'b0;
        end else if (clkEn) begin
            if (!(modeWide && runLower && runUpper)) begin
                wideRun_r   <= 1'b0;
                widePhase_r <= 1'b0;
            end else if (!wideRun_r) begin
                wideRun_r   <= 1'b1;
                widePhase_r <= 1'b0;
                wideCnt_r   <= wideLow;
            end else if (wideUf) begin
                // reload plus one ticks; both halves
                widePhase_r <= ~widePhase_r;
                wideCnt_r   <= widePhase_r ? wideLow : wideHigh;
            end else if (lowerTick) begin
                wideCnt_r <= wideCnt_r - 16'h0001;
            end
        end
    end

    // independent underflow per channel; wide sets both
    assign ufLowerEv = modeWide ? wideUf : ufRawLower;
    assign ufUpperEv = modeWide ? wideUf : ufRawUpper;

    // ************************************************************
    // control registers
    // ************************************************************
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            lowerCtrl_r       <= CTRL_RESET;
            upperCtrl_r       <= CTRL_RESET;
            pairSel_r         <= PAIR_RESET;
            lowReloadLower_r  <= RELOAD_RESET;
            highReloadLower_r <= RELOAD_RESET;
            lowReloadUpper_r  <= RELOAD_RESET;
            highReloadUpper_r <= RELOAD_RESET;
        end else if (clkEn) begin
            if (wrLowerCtrl) begin
                lowerCtrl_r <= regWdata[7:0];
            end
            if (wrUpperCtrl) begin
                upperCtrl_r <= regWdata[7:0];
            end
            if (wrPair) begin
                pairSel_r <= regWdata[7:0];
            end
            // reload pair written as one word
            if (wrRelLower) begin
                lowReloadLower_r  <= regWdata[7:0];
                highReloadLower_r <= regWdata[15:8];
            end
            if (wrRelUpper) begin
                lowReloadUpper_r  <= regWdata[7:0];
                highReloadUpper_r <= regWdata[15:8];
            end
        end
    end

    // ************************************************************
    // underflow flags
    // ************************************************************
    logic clrLower;
    logic clrUpper;

    // write zero clears, one has no effect
    assign clrLower = (wrLowerCtrl && !regWdata[BIT_UF_FLAG]) ||
                      (wrStatus && !regWdata[0]);
    assign clrUpper = (wrUpperCtrl && !regWdata[BIT_UF_FLAG]) ||
                      (wrStatus && !regWdata[1]);

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ufLower_r <= 1'b0;
            ufUpper_r <= 1'b0;
        end else if (clkEn) begin
            if (ufLowerEv) begin
                ufLower_r <= 1'b1;
            end else if (clrLower) begin
                ufLower_r <= 1'b0;
            end
            if (ufUpperEv) begin
                ufUpper_r <= 1'b1;
            end else if (clrUpper) begin
                ufUpper_r <= 1'b0;
            end
        end
    end

    // ************************************************************
    // pins and requests
    // ************************************************************
    logic pulseA;
    logic pulseB;
    logic pinLowerNxt;
    logic pinUpperNxt;
    logic irqLowerNxt;
    logic irqUpperNxt;
    logic wideIrq;

    assign pulseA = modeWide ? widePhase_r : (runLower && levelLower);
    assign pulseB = modeWide ? widePhase_r : (runUpper && levelUpper);
    // swap; wide pins identical when either enabled
    assign pinLowerNxt = modeWide ?
        (pulseA && (lowerCtrl_r[BIT_PIN_EN] || upperCtrl_r[BIT_PIN_EN])) :
        (lowerCtrl_r[BIT_PIN_EN] &&
         (pairSel_r[BIT_SWAP] ? pulseB : pulseA));
    assign pinUpperNxt = modeWide ?
        (pulseA && (lowerCtrl_r[BIT_PIN_EN] || upperCtrl_r[BIT_PIN_EN])) :
        (upperCtrl_r[BIT_PIN_EN] &&
         (pairSel_r[BIT_SWAP] ? pulseA : pulseB));
    assign wideIrq = (ufLower_r && lowerCtrl_r[BIT_IRQ_EN]) ||
                     (ufUpper_r && upperCtrl_r[BIT_IRQ_EN]);
    assign irqLowerNxt = modeWide ? (wideIrq && lowerCtrl_r[BIT_IRQ_EN]) :
                         (ufLower_r && lowerCtrl_r[BIT_IRQ_EN]);
    assign irqUpperNxt = modeWide ? (wideIrq && upperCtrl_r[BIT_IRQ_EN]) :
                         (ufUpper_r && upperCtrl_r[BIT_IRQ_EN]);

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pinLower_r <= 1'b0;
            pinUpper_r <= 1'b0;
            irqLower_r <= 1'b0;
            irqUpper_r <= 1'b0;
        end else if (clkEn) begin
            pinLower_r <= pinLowerNxt;
            pinUpper_r <= pinUpperNxt;
            irqLower_r <= irqLowerNxt;
            irqUpper_r <= irqUpperNxt;
        end
    end

    // ************************************************************
    // read port
    // ************************************************************
    logic [15:0] rdMux;

    always_comb begin
        case (regAddr)
            REG_LOWER_CTRL: rdMux = {8'h00, lowerCtrl_r[7:5], ufLower_r,
                                     lowerCtrl_r[3:0]};
            REG_UPPER_CTRL: rdMux = {8'h00, upperCtrl_r[7:5], ufUpper_r,
                                     upperCtrl_r[3:0]};
            REG_PAIR_SEL:   rdMux = {8'h00, pairSel_r};
            REG_RELOAD_LOW: rdMux = {highReloadLower_r, lowReloadLower_r};
            REG_RELOAD_UP:  rdMux = {highReloadUpper_r, lowReloadUpper_r};
            REG_STATUS:     rdMux = {12'h000, pulseB, pulseA,
                                     ufUpper_r, ufLower_r};
            default:        rdMux = 16'h0000;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            regRdata_r <= 16'h0000;
        end else if (clkEn) begin
            regRdata_r <= regRd ? rdMux : 16'h0000;
        end
    end

    assign regRdata      = regRdata_r;
    assign pulsePinLower = pinLower_r;
    assign pulsePinUpper = pinUpper_r;
    assign irqLower      = irqLower_r;
    assign irqUpper      = irqUpper_r;
endmodule

// [dpg_top_checker.sv]
// checker: bound properties on the pulse generator pins and requests
`timescale 1ns/100ps
module dpg_top_checker
    import dpg_pkg::*;
(
    // clocking
    input wire logic        clk_sys,
    input wire logic        rst,
    // register port
    input wire logic [2:0]  regAddr,
    input wire logic [15:0] regWdata,
    input wire logic        regWr,
    // pins and requests
    input wire logic        pulsePinLower,
    input wire logic        pulsePinUpper,
    input wire logic        irqLower,
    input wire logic        irqUpper
);
    // ************************************************************
    // shadow of configuration writes
    // ************************************************************
    logic [7:0] ctlLo_r;
    logic [7:0] ctlUp_r;
    logic       swap_r;
    logic [2:0] age_r;
    logic       wide;
    logic       loPin;
    logic       upPin;
    assign wide  = ctlUp_r[3:2] == MODE_WIDE;
    assign loPin = swap_r ? pulsePinUpper : pulsePinLower;
    assign upPin = swap_r ? pulsePinLower : pulsePinUpper;
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ctlLo_r <= CTRL_RESET;
            ctlUp_r <= CTRL_RESET;
            swap_r  <= 1'b0;
            age_r   <= 3'h0;
        end else begin
            if (regWr && regAddr == REG_LOWER_CTRL) ctlLo_r <= regWdata[7:0];
            if (regWr && regAddr == REG_UPPER_CTRL) ctlUp_r <= regWdata[7:0];
            if (regWr && regAddr == REG_PAIR_SEL) swap_r <= regWdata[BIT_SWAP];
            if (regWr && regAddr <= REG_PAIR_SEL) age_r <= 3'h0;
            else if (age_r != 3'h7) age_r <= age_r + 3'h1;
        end
    end
    // ************************************************************
    // properties
    // ************************************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    sequence stopLoWr;
        regWr && regAddr == REG_LOWER_CTRL && !regWdata[BIT_RUN_EN];
    endsequence
    sequence stopUpWr;
        regWr && regAddr == REG_UPPER_CTRL && !regWdata[BIT_RUN_EN];
    endsequence
    reset_quiet_a: assert property (
        $fell(rst) |-> !pulsePinLower && !pulsePinUpper && !irqLower && !irqUpper)
        else $error("outputs not low after reset");
    stop_lower_a: assert property (stopLoWr |-> ##[1:4] !loPin)
        else $error("lower channel pin not low after stop");
    stop_upper_a: assert property (stopUpWr |-> ##[1:4] !upPin)
        else $error("upper channel pin not low after stop");
    wide_stop_a: assert property (
        stopLoWr ##0 wide |-> ##[1:4] (!pulsePinLower && !pulsePinUpper))
        else $error("wide counter not halted");
    wide_pins_eq_a: assert property (
        age_r == 3'h7 && wide && (ctlLo_r[BIT_PIN_EN] || ctlUp_r[BIT_PIN_EN])
        |-> pulsePinLower == pulsePinUpper)
        else $error("wide mode pins differ");
    irq_mask_lower_a: assert property (age_r == 3'h7 && !ctlLo_r[BIT_IRQ_EN] |-> !irqLower)
        else $error("lower request while disabled");
    irq_mask_upper_a: assert property (age_r == 3'h7 && !ctlUp_r[BIT_IRQ_EN] |-> !irqUpper)
        else $error("upper request while disabled");
    halted_low_a: assert property (
        age_r == 3'h7 && !ctlLo_r[BIT_RUN_EN] && !ctlUp_r[BIT_RUN_EN]
        |-> !pulsePinLower && !pulsePinUpper)
        else $error("pin high while both channels off");
endmodule

bind dpg_top dpg_top_checker chk (.clk_sys(clk_sys), .rst(rst), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .pulsePinLower(pulsePinLower),
    .pulsePinUpper(pulsePinUpper), .irqLower(irqLower), .irqUpper(irqUpper));

// [dpg_top_tb_top.sv]
// testbench: register-driven scenarios for the pulse generator
`timescale 1ns/100ps
module dpg_top_tb_top
    import dpg_pkg::*;
;
    localparam int CYCLE_LIMIT = 40000;
    logic        clk_sys     = 1'b0;
    logic        rst         = 1'b1;
    logic        timebaseTap = 1'b0;
    logic [3:0]  tbCnt       = 4'h0;
    logic [2:0]  regAddr     = 3'h0;
    logic [15:0] regWdata    = 16'h0000;
    logic        regWr       = 1'b0;
    logic        regRd       = 1'b0;
    logic        rdQ         = 1'b0;
    logic [15:0] regRdata;
    logic        pulsePinLower;
    logic        pulsePinUpper;
    logic        irqLower;
    logic        irqUpper;
    logic [31:0] expQ[$];
    int          mismatches  = 0;
    int          n_checks    = 0;
    int          cycles      = 0;
    int          seed        = 68350;
    logic [7:0]  rl;
    logic [7:0]  rh;
    logic [2:0]  csTab[6]    = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, CS_TIMEBASE};
    int          dvTab[6]    = '{1, 2, 4, 8, 16, 16};

    dpg_top uut (.clk_sys(clk_sys), .rst(rst), .clkEn(1'b1), .timebaseTap(timebaseTap),
        .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
        .regRdata(regRdata), .pulsePinLower(pulsePinLower), .pulsePinUpper(pulsePinUpper),
        .irqLower(irqLower), .irqUpper(irqUpper));

    // ************************************************************
    // clock, tap, monitor, timeout
    // ************************************************************
    always #5 clk_sys = ~clk_sys;
    // tap rises every 16 cycles
    always @(posedge clk_sys) begin
        tbCnt       <= tbCnt + 4'h1;
        timebaseTap <= tbCnt[3];
        rdQ         <= regRd;
        cycles      <= cycles + 1;
        if (cycles == CYCLE_LIMIT) begin
            mismatches++;
            end_of_test();
        end
    end
    always @(negedge clk_sys) begin
        if (rdQ && expQ.size() > 0) begin
            chk_rd(regRdata, expQ.pop_front());
        end
    end

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk_rd(input logic [15:0] got, input logic [31:0] e);
        n_checks++;
        if ((got & e[31:16]) !== e[15:0]) begin
            mismatches++;
            $display("[FAIL] %0t read %h expected %h", $time, got, e[15:0]);
        end
    endtask
    task automatic chk_v(input logic [15:0] got, input logic [15:0] e);
        n_checks++;
        if (got !== e) begin
            mismatches++;
            $display("[FAIL] %0t value %h expected %h", $time, got, e);
        end
    endtask
    task automatic bus(input logic w, input logic r, input logic [2:0] a,
                       input logic [15:0] d);
        @(posedge clk_sys);
        regWr    <= w;
        regRd    <= r;
        regAddr  <= a;
        regWdata <= d;
    endtask
    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        bus(1'b1, 1'b0, a, d);
    endtask
    task automatic rd(input logic [2:0] a, input logic [15:0] e, input logic [15:0] m);
        expQ.push_back({m, e});
        bus(1'b0, 1'b1, a, 16'h0000);
    endtask
    task automatic cyc(input int n);
        repeat (n) bus(1'b0, 1'b0, 3'h0, 16'h0000);
        @(negedge clk_sys);
    endtask
    function automatic logic pv(input logic s);
        return s ? pulsePinUpper : pulsePinLower;
    endfunction
    task automatic span(input logic s, input logic v, output int c);
        c = 0;
        while (pv(s) === v && c < 3000) begin
            @(negedge clk_sys);
            c++;
        end
    endtask
    // skips a partial phase, then times one high and one low phase
    task automatic meas(input logic s, input int eh, input int el);
        int hi;
        int lo;
        cyc(1);
        span(s, 1'b1, hi);
        span(s, 1'b0, lo);
        span(s, 1'b1, hi);
        span(s, 1'b0, lo);
        chk_v(16'(hi), 16'(eh));
        chk_v(16'(lo), 16'(el));
    endtask

    // ************************************************************
    // scenarios
    // ************************************************************
    initial begin
        repeat (20) @(posedge clk_sys);
        rst <= 1'b0;
        wr(3'h6, 16'hffff);
        wr(3'h7, 16'hffff);
        for (int a = 0; a < 8; a++) rd(3'(a), 16'h0000, 16'hffff);
        rl = 8'($random(seed));
        rh = 8'($random(seed));
        wr(REG_RELOAD_LOW, {rh, rl});
        wr(REG_RELOAD_UP, 16'hff00);
        wr(REG_LOWER_CTRL, 16'h00e0);
        cyc(600);
        chk_v(16'(pulsePinUpper), 16'h0000);
        rd(REG_STATUS, 16'h0001, 16'h000b);
        wr(REG_UPPER_CTRL, 16'h00e0);
        meas(1'b0, rh + 1, rl + 1);
        meas(1'b1, 256, 1);
        chk_v(16'({irqLower, irqUpper}), 16'h0003);
        wr(REG_PAIR_SEL, 16'h0001);
        meas(1'b1, rh + 1, rl + 1);
        meas(1'b0, 256, 1);
        wr(REG_PAIR_SEL, 16'h0000);
        wr(REG_LOWER_CTRL, 16'h0020);
        wr(REG_STATUS, 16'h0002);
        meas(1'b1, 256, 1);
        chk_v(16'({pulsePinLower, irqLower}), 16'h0000);
        rd(REG_STATUS, 16'h0002, 16'h0007);
        wr(REG_UPPER_CTRL, 16'h00c0);
        cyc(4);
        chk_v(16'(irqUpper), 16'h0000);
        wr(REG_UPPER_CTRL, 16'h0000);
        wr(REG_RELOAD_LOW, 16'h0203);
        wr(REG_RELOAD_UP, 16'h0302);
        for (int i = 0; i < 6; i++) begin
            wr(REG_PAIR_SEL, {8'h00, csTab[i], csTab[i], 2'b00});
            wr(REG_LOWER_CTRL, 16'h00c0);
            wr(REG_UPPER_CTRL, 16'h00c0);
            meas(1'b0, 3 * dvTab[i], 4 * dvTab[i]);
            meas(1'b1, 4 * dvTab[i], 3 * dvTab[i]);
            wr(REG_LOWER_CTRL, 16'h0000);
            wr(REG_UPPER_CTRL, 16'h0000);
        end
        wr(REG_PAIR_SEL, 16'h0014);
        wr(REG_LOWER_CTRL, 16'h00c0);
        cyc(100);
        chk_v(16'(pulsePinLower), 16'h0000);
        wr(REG_LOWER_CTRL, 16'h0000);
        wr(REG_PAIR_SEL, 16'h0000);
        wr(REG_STATUS, 16'h0000);
        rl = 8'($random(seed));
        wr(REG_RELOAD_LOW, {8'h04, rl});
        wr(REG_RELOAD_UP, 16'h0001);
        wr(REG_UPPER_CTRL, 16'h002c);
        wr(REG_LOWER_CTRL, 16'h00c0);
        wr(REG_UPPER_CTRL, 16'h00ac);
        meas(1'b0, 5, 257 + rl);
        meas(1'b1, 5, 257 + rl);
        chk_v(16'({irqLower, irqUpper}), 16'h0001);
        rd(REG_STATUS, 16'h0003, 16'h0003);
        wr(REG_LOWER_CTRL, 16'h0000);
        wr(REG_UPPER_CTRL, 16'h000c);
        cyc(6);
        chk_v(16'({pulsePinLower, pulsePinUpper}), 16'h0000);
        // cascade: upper counts lower underflows, two cycles apart
        wr(REG_RELOAD_LOW, 16'h0101);
        wr(REG_RELOAD_UP, 16'h0201);
        wr(REG_LOWER_CTRL, 16'h00c0);
        wr(REG_UPPER_CTRL, 16'h00c4);
        meas(1'b0, 2, 2);
        meas(1'b1, 6, 4);
        end_of_test();
    end
endmodule
